// [rtl/hfl_pkg.sv]
// package of the multicast hash filter and latency timer register bank
// assumes a 200 MHz system clock and 32-bit AXI4-Lite register access
package hfl_pkg;
    // register indexes; byte address is four times the index
    localparam logic [15:0] HFL_IDX_TIMER = 16'h001A;
    localparam logic [15:0] HFL_IDX_HASH = 16'h0028;
    localparam logic [15:0] HFL_IDX_CONFIG = 16'h0029;
    localparam logic [15:0] HFL_IDX_SPEED = 16'h1C88;
    localparam logic [15:0] HFL_IDX_HASH_CMD = 16'h0040;
    localparam logic [15:0] HFL_IDX_CFG_CMD = 16'h0041;
    localparam logic [15:0] HFL_IDX_IRQ_CMD = 16'h0042;
    localparam logic [15:0] HFL_IDX_IRQ_STAT = 16'h0043;
    localparam int HFL_ADDR_W = 16;
    // field positions
    localparam int HFL_HCMD_VAL_BIT = 10;
    localparam int HFL_HCMD_IDX_LSB = 0;
    localparam int HFL_CFG_W = 4;
    localparam int HFL_CFG_HASH_EN_BIT = 0;
    localparam int HFL_SPEED_RATE_BIT = 1;
    localparam int HFL_IRQ_REQ_BIT = 0;
    localparam int HFL_IRQ_CLR_BIT = 1;
    // reset values
    localparam logic [15:0] HFL_SPEED_RST = 16'h3201;
    localparam logic [3:0] HFL_CFG_RST = 4'h0;
    localparam logic [7:0] HFL_TIMER_MAX = 8'hFF;
    // response codes
    localparam logic [1:0] HFL_RESP_OKAY = 2'h0;
    localparam logic [1:0] HFL_RESP_SLVERR = 2'h2;
    // timing: one latency tick every 2 us on a 5 ns clock
    localparam int HFL_CLK_PERIOD_PS = 5000;
    localparam int HFL_TICK_PS = 2000000;
    localparam int HFL_TICK_CYC = HFL_TICK_PS / HFL_CLK_PERIOD_PS;
    localparam int HFL_PRE_W = 9;
    localparam logic [HFL_PRE_W-1:0] HFL_PRE_LAST = HFL_PRE_W'(HFL_TICK_CYC - 1);

    // replaceable destination address hash: xor fold of 48 bits to 6
    function automatic logic [5:0] hfl_hash6(input logic [47:0] addr);
        logic [5:0] h;
        h = 6'h00;
        for (int i = 0; i < 8; i++) begin
            h = h ^ addr[i*6 +: 6];
        end
        return h;
    endfunction

    // word index from an AXI byte address
    function automatic logic [15:0] hfl_index(input logic [HFL_ADDR_W+1:0] byte_addr);
        return byte_addr[HFL_ADDR_W+1:2];
    endfunction
endpackage

// [rtl/hfl_mem_if.sv]
// interface between the register bank and its hash table store
// assumes both ends run on the same system clock
`timescale 1ns/10ps
interface hfl_mem_if;
    logic wr_en;
    logic [5:0] wr_idx;
    logic wr_val;
    logic [2:0] rd_sel;
    logic [7:0] rd_byte;
    logic [5:0] lk_idx;
    logic lk_bit;
    modport ctrl (output wr_en, wr_idx, wr_val, rd_sel, lk_idx, input rd_byte, lk_bit);
    modport mem (input wr_en, wr_idx, wr_val, rd_sel, lk_idx, output rd_byte, lk_bit);
endinterface

// [rtl/hfl_hash_mem.sv]
// 64-entry multicast hash table with bit write and registered byte read
// assumes the controller drives the interface from the same clock
`timescale 1ns/10ps
module hfl_hash_mem (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    hfl_mem_if.mem mem
);
    import hfl_pkg::*;
    logic [63:0] table_reg;
    logic [7:0] rd_byte_reg;
    logic lk_bit_reg;

    // per-entry update, cleared at reset
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            table_reg <= 64'h0; // [RL3]
        end else if (ce_i && mem.wr_en) begin
            table_reg[mem.wr_idx] <= mem.wr_val; // [RL2] [RL4]
        end
    end

    // registered byte read and entry lookup
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_byte_reg <= 8'h00;
            lk_bit_reg <= 1'b0;
        end else if (ce_i) begin
            rd_byte_reg <= table_reg[mem.rd_sel*8 +: 8]; // [RL1]
            lk_bit_reg <= table_reg[mem.lk_idx];
        end
    end

    assign mem.rd_byte = rd_byte_reg;
    assign mem.lk_bit = lk_bit_reg;
endmodule // hfl_hash_mem

// [rtl/hfl_lat_timer.sv]
// 8-bit interrupt latency counter with a 2 us tick
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/10ps
module hfl_lat_timer (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic start_i,
    output logic [7:0] count_o
);
    import hfl_pkg::*;
    logic [HFL_PRE_W-1:0] pre_reg;
    logic [7:0] cnt_reg;
    logic tick;

    assign tick = (pre_reg == HFL_PRE_LAST);

    // tick prescaler, realigned at each start
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_reg <= '0;
        end else if (ce_i) begin
            if (start_i || tick) begin
                pre_reg <= '0;
            end else begin
                pre_reg <= pre_reg + 1'b1; // [RL8]
            end
        end
    end

    // count from zero, halt at full scale
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= 8'h00;
        end else if (ce_i) begin
            if (start_i) begin
                cnt_reg <= 8'h00; // [RL7]
            end else if (tick && cnt_reg != HFL_TIMER_MAX) begin
                cnt_reg <= cnt_reg + 8'h01; // [RL8] [RL9]
            end
        end
    end

    assign count_o = cnt_reg;
endmodule // hfl_lat_timer

// [rtl/hfl_regs.sv]
// hash filter, ring speed and interrupt latency register bank, AXI4-Lite slave
// assumes AXI4-Lite master on clk_sys_i; lookup requests come from local logic
//
// Overview of operation
// [RL1] The 64-bit hash table reads as eight byte reads, low byte first.
// [RL2] A hash bit select write sets or clears the entry at bits 5:0 per bit 10.
// [RL3] Reset clears every hash table entry.
// [RL4] The table has 64 entries indexed by a 6-bit hash; software rechecks hits.
// [RL5] Software sets table entries first, then sets the hash enable by config.
// [RL6] Bit 1 of the ring speed setting picks 16 Mbps when 0, 4 Mbps when 1.
// [RL7] The latency counter restarts at zero when the interrupt asserts.
// [RL8] The latency counter counts up once every 2 us of the system clock.
// [RL9] The latency counter holds at FFh instead of wrapping.
// [RL10] A pending interrupt latch stops a request from restarting the counter.
// [RL11] Config bit 0 enables hash filtering; clear means the table is ignored.
// [RL12] The address hash is a replaceable function giving a 6-bit index.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module hfl_regs (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // axi4-lite write address
    input wire logic [hfl_pkg::HFL_ADDR_W+1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [hfl_pkg::HFL_ADDR_W+1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // multicast lookup
    input wire logic [47:0] mcast_addr_i,
    input wire logic mcast_valid_i,
    output logic mcast_accept_o,
    output logic mcast_done_o,
    // interrupt side and ring rate select
    input wire logic irq_event_i,
    output logic irq_o,
    output logic ring_rate_select_o
);
    import hfl_pkg::*;

    hfl_mem_if mif ();

    logic aw_rdy_reg, w_rdy_reg, aw_have_reg, w_have_reg;
    logic [15:0] aw_idx_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic ar_rdy_reg, ar_have_reg, rvalid_reg;
    logic [15:0] ar_idx_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [2:0] hash_ptr_reg;
    logic [3:0] config_reg;
    logic [15:0] speed_reg;
    logic rate_reg;
    logic pending_irq_latch_reg;
    logic irq_prev_reg;
    logic lk_pend_reg;
    logic accept_reg, done_reg;
    logic [7:0] latency_count;
    logic wr_fire, rd_fire;
    logic wr_hash_cmd, wr_cfg_cmd, wr_irq_cmd, wr_speed, wr_known;
    logic irq_request, irq_clear, timer_start;
    logic [31:0] rd_word;
    logic rd_known;

    // a write is carried out once address and data are both held
    assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    assign rd_fire = ar_have_reg && !rvalid_reg;

    // write address decode
    always_comb begin
        wr_hash_cmd = 1'b0;
        wr_cfg_cmd = 1'b0;
        wr_irq_cmd = 1'b0;
        wr_speed = 1'b0;
        wr_known = 1'b1;
        if (aw_idx_reg == HFL_IDX_HASH_CMD) begin
            wr_hash_cmd = 1'b1;
        end else if (aw_idx_reg == HFL_IDX_CFG_CMD) begin
            wr_cfg_cmd = 1'b1;
        end else if (aw_idx_reg == HFL_IDX_IRQ_CMD) begin
            wr_irq_cmd = 1'b1;
        end else if (aw_idx_reg == HFL_IDX_SPEED) begin
            wr_speed = 1'b1;
        end else if (aw_idx_reg == HFL_IDX_TIMER || aw_idx_reg == HFL_IDX_HASH ||
                     aw_idx_reg == HFL_IDX_CONFIG || aw_idx_reg == HFL_IDX_IRQ_STAT) begin
            wr_known = 1'b1; // read-only: write ignored
        end else begin
            wr_known = 1'b0;
        end
    end

    // write address channel
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_rdy_reg <= 1'b1;
            aw_have_reg <= 1'b0;
            aw_idx_reg <= 16'h0000;
        end else if (ce_i) begin
            if (s_axi_awvalid && aw_rdy_reg) begin
                aw_rdy_reg <= 1'b0;
                aw_have_reg <= 1'b1;
                aw_idx_reg <= hfl_index(s_axi_awaddr);
            end else if (bvalid_reg && s_axi_bready) begin
                aw_rdy_reg <= 1'b1;
                aw_have_reg <= 1'b0;
            end
        end
    end

    // write data channel
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w_rdy_reg <= 1'b1;
            w_have_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else if (ce_i) begin
            if (s_axi_wvalid && w_rdy_reg) begin
                w_rdy_reg <= 1'b0;
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (bvalid_reg && s_axi_bready) begin
                w_rdy_reg <= 1'b1;
                w_have_reg <= 1'b0;
            end
        end
    end

    // write response, error for unmapped addresses
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= HFL_RESP_OKAY;
        end else if (ce_i) begin
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? HFL_RESP_OKAY : HFL_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // hash bit select command drives the table write port
    assign mif.wr_en = ce_i && wr_fire && wr_hash_cmd && wstrb_reg[1] && wstrb_reg[0];
    assign mif.wr_val = wdata_reg[HFL_HCMD_VAL_BIT]; // [RL2]
    assign mif.wr_idx = wdata_reg[HFL_HCMD_IDX_LSB +: 6]; // [RL2]
    assign mif.rd_sel = hash_ptr_reg;
    assign mif.lk_idx = hfl_hash6(mcast_addr_i); // [RL12]

    // configuration written only through the config command
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            config_reg <= HFL_CFG_RST;
        end else if (ce_i && wr_fire && wr_cfg_cmd && wstrb_reg[0]) begin
            config_reg <= wdata_reg[HFL_CFG_W-1:0]; // [RL5] [RL11]
        end
    end

    // ring speed setting with byte strobes
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            speed_reg <= HFL_SPEED_RST;
            rate_reg <= HFL_SPEED_RST[HFL_SPEED_RATE_BIT];
        end else if (ce_i && wr_fire && wr_speed) begin
            if (wstrb_reg[0]) begin
                speed_reg[7:0] <= wdata_reg[7:0];
                rate_reg <= wdata_reg[HFL_SPEED_RATE_BIT]; // [RL6]
            end
            if (wstrb_reg[1]) begin
                speed_reg[15:8] <= wdata_reg[15:8];
            end
        end
    end

    // interrupt latch: set wins over clear
    assign irq_request = (wr_fire && wr_irq_cmd && wstrb_reg[0] &&
                          wdata_reg[HFL_IRQ_REQ_BIT]) || irq_event_i;
    assign irq_clear = wr_fire && wr_irq_cmd && wstrb_reg[0] && wdata_reg[HFL_IRQ_CLR_BIT];
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_irq_latch_reg <= 1'b0;
        end else if (ce_i) begin
            if (irq_request) begin
                pending_irq_latch_reg <= 1'b1;
            end else if (irq_clear) begin
                pending_irq_latch_reg <= 1'b0;
            end
        end
    end

    // counter starts only on a fresh assertion of the interrupt
    assign timer_start = pending_irq_latch_reg && !irq_prev_reg; // [RL7] [RL10]
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_prev_reg <= 1'b0;
        end else if (ce_i) begin
            irq_prev_reg <= pending_irq_latch_reg;
        end
    end

    hfl_lat_timer u_timer (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .start_i(timer_start),
        .count_o(latency_count)
    );

    hfl_hash_mem u_hash (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .mem(mif.mem)
    );

    // read address decode
    always_comb begin
        rd_word = 32'h00000000;
        rd_known = 1'b1;
        if (ar_idx_reg == HFL_IDX_TIMER) begin
            rd_word[7:0] = latency_count;
        end else if (ar_idx_reg == HFL_IDX_HASH) begin
            rd_word[7:0] = mif.rd_byte; // [RL1]
        end else if (ar_idx_reg == HFL_IDX_CONFIG) begin
            rd_word[HFL_CFG_W-1:0] = config_reg;
        end else if (ar_idx_reg == HFL_IDX_SPEED) begin
            rd_word[15:0] = speed_reg;
        end else if (ar_idx_reg == HFL_IDX_IRQ_STAT) begin
            rd_word[HFL_IRQ_REQ_BIT] = pending_irq_latch_reg;
        end else if (ar_idx_reg == HFL_IDX_HASH_CMD || ar_idx_reg == HFL_IDX_CFG_CMD ||
                     ar_idx_reg == HFL_IDX_IRQ_CMD) begin
            rd_known = 1'b1; // command registers read as zero
        end else begin
            rd_known = 1'b0;
        end
    end

    // read address channel
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ar_rdy_reg <= 1'b1;
            ar_have_reg <= 1'b0;
            ar_idx_reg <= 16'h0000;
        end else if (ce_i) begin
            if (s_axi_arvalid && ar_rdy_reg) begin
                ar_rdy_reg <= 1'b0;
                ar_have_reg <= 1'b1;
                ar_idx_reg <= hfl_index(s_axi_araddr);
            end else if (rvalid_reg && s_axi_rready) begin
                ar_rdy_reg <= 1'b1;
                ar_have_reg <= 1'b0;
            end
        end
    end

    // read data channel
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= HFL_RESP_OKAY;
        end else if (ce_i) begin
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= rd_known ? HFL_RESP_OKAY : HFL_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // hash byte pointer steps after each hash read, wraps after eight
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hash_ptr_reg <= 3'h0;
        end else if (ce_i && rd_fire && ar_idx_reg == HFL_IDX_HASH) begin
            hash_ptr_reg <= hash_ptr_reg + 3'h1; // [RL1]
        end
    end

    // multicast lookup: answer two cycles after the request
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lk_pend_reg <= 1'b0;
            accept_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (ce_i) begin
            lk_pend_reg <= mcast_valid_i;
            done_reg <= lk_pend_reg;
            if (lk_pend_reg) begin
                accept_reg <= !config_reg[HFL_CFG_HASH_EN_BIT] || mif.lk_bit; // [RL11] [RL4]
            end
        end
    end

    assign s_axi_awready = aw_rdy_reg;
    assign s_axi_wready = w_rdy_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ar_rdy_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign mcast_accept_o = accept_reg;
    assign mcast_done_o = done_reg;
    assign irq_o = pending_irq_latch_reg;
    assign ring_rate_select_o = rate_reg;
endmodule // hfl_regs

// [verif/hfl_chk.sv]
// assertions on the ports of the hash filter and latency timer register bank
// assumes one clock domain
`timescale 1ns/10ps
module hfl_chk (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mcast_valid_i,
    input wire logic mcast_accept_o,
    input wire logic mcast_done_o,
    input wire logic irq_event_i,
    input wire logic irq_o,
    input wire logic ring_rate_select_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    // bus answers and their holding
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not held");
    busy_ready_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken before answer");
    // side outputs move only through their causes
    rate_change_a: assert property ($changed(ring_rate_select_o) |-> $rose(s_axi_bvalid))
        else $error("rate changed without write");
    irq_set_a: assert property (irq_event_i |=> irq_o)
        else $error("event did not set latch");
    irq_clear_a: assert property ($fell(irq_o) |-> $rose(s_axi_bvalid))
        else $error("latch cleared without write");
    lookup_lat_a: assert property (mcast_valid_i |-> ##2 mcast_done_o)
        else $error("lookup answer late");
    accept_hold_a: assert property (!mcast_done_o |-> $stable(mcast_accept_o))
        else $error("lookup result not held");

    cover property (s_axi_rvalid && s_axi_rready);
    cover property (mcast_done_o && mcast_accept_o);
    cover property ($rose(irq_o));
endmodule // hfl_chk

bind hfl_regs hfl_chk hfl_chk_i (.*);

// [verif/hfl_host.sv]
// host driver model: an axi4-lite master with word read and write tasks
// assumes registered slave outputs that change only on the rising edge
`timescale 1ns/10ps
module hfl_host (
    input wire logic clk_sys_i,
    output logic [hfl_pkg::HFL_ADDR_W+1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [hfl_pkg::HFL_ADDR_W+1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    import hfl_pkg::*;

    // idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    end

    // write one word
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] st,
                      output logic [1:0] r);
        logic a, w, b;
        @(posedge clk_sys_i);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge clk_sys_i);
            a = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_sys_i);
            if (a) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            if (w) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end
        s_axi_bready <= 1'b0;
    endtask

    // read one word
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic a, v;
        @(posedge clk_sys_i);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        v = 1'b0;
        while (!v) begin
            @(negedge clk_sys_i);
            a = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys_i);
            if (a) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~s_axi_araddr;
            end
        end
        s_axi_rready <= 1'b0;
    endtask
endmodule // hfl_host

// [verif/hfl_regs_bench.sv]
// self-checking bench of the hash filter and latency timer register bank
// assumes the host model for bus traffic and the bound port checker
`timescale 1ns/10ps
module hfl_regs_bench;
    import hfl_pkg::*;
    logic clk_sys_i, reset_n_i, ce_i, mcast_valid_i, irq_event_i;
    logic [HFL_ADDR_W+1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [47:0] mcast_addr_i;
    logic mcast_accept_o, mcast_done_o, irq_o, ring_rate_select_o;
    int num_errors, num_checks;

    hfl_regs hfl_regs_i (.*);
    hfl_host hfl_host_i (.*);

    // 200 MHz system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        hfl_host_i.rd(idx, d, r);
        chk(d, exp, "read data");
        chk(32'(r), 32'(er), "read response");
    endtask

    task automatic wrc(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] st,
                       input logic [1:0] er);
        logic [1:0] r;
        hfl_host_i.wr(idx, d, st, r);
        chk(32'(r), 32'(er), "write response");
    endtask

    // one lookup request; the answer stands one edge after it is taken
    task automatic lk(input logic [47:0] a, input logic exp);
        @(posedge clk_sys_i);
        mcast_addr_i <= a;
        mcast_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        mcast_valid_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk(mcast_done_o, 1'b1, "lookup done");
        chk(mcast_accept_o, exp, "lookup result");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // tests
    initial begin
        {reset_n_i, mcast_valid_i, irq_event_i, ce_i} = 4'h1;
        mcast_addr_i = 48'h0;
        num_errors = 0;
        num_checks = 0;
        repeat (10) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rdc(HFL_IDX_SPEED, 32'h0000_3201, HFL_RESP_OKAY);
        chk(ring_rate_select_o, 1'b0, "rate after reset");
        rdc(HFL_IDX_TIMER, 32'h0, HFL_RESP_OKAY);
        for (int k = 0; k < 8; k++) rdc(HFL_IDX_HASH, 32'h0, HFL_RESP_OKAY);
        rdc(16'h0100, 32'h0, HFL_RESP_SLVERR);
        wrc(16'h0100, 32'hFFFF_FFFF, 4'hF, HFL_RESP_SLVERR);
        $display("test reset done");
        // entry 9k lands in byte k as bit k
        for (int k = 0; k < 8; k++)
            wrc(HFL_IDX_HASH_CMD, {21'h0, 1'b1, 4'h0, 6'(k * 9)}, 4'h3, HFL_RESP_OKAY);
        wrc(HFL_IDX_HASH, 32'hFFFF_FFFF, 4'hF, HFL_RESP_OKAY);
        for (int k = 0; k < 8; k++) rdc(HFL_IDX_HASH, 32'(1 << k), HFL_RESP_OKAY);
        wrc(HFL_IDX_HASH_CMD, {21'h0, 1'b0, 4'h0, 6'h09}, 4'h3, HFL_RESP_OKAY);
        for (int k = 0; k < 8; k++)
            rdc(HFL_IDX_HASH, (k == 1) ? 32'h0 : 32'(1 << k), HFL_RESP_OKAY);
        $display("test hash done");
        lk(48'h0000_0000_0009, 1'b1);
        wrc(HFL_IDX_CFG_CMD, 32'h1, 4'h1, HFL_RESP_OKAY);
        rdc(HFL_IDX_CONFIG, 32'h1, HFL_RESP_OKAY);
        lk(48'h0000_0000_0009, 1'b0);
        lk(48'h0000_0000_0012, 1'b1);
        lk(48'h0000_0000_0480, 1'b1); // folds onto entry 0x12 as well
        lk(48'h0000_0000_0481, 1'b0);
        wrc(HFL_IDX_CFG_CMD, 32'h0, 4'h1, HFL_RESP_OKAY);
        lk(48'h0000_0000_0009, 1'b1);
        $display("test lookup done");
        wrc(HFL_IDX_SPEED, 32'h0, 4'h3, HFL_RESP_OKAY);
        chk(ring_rate_select_o, 1'b0, "rate 16 Mbps");
        wrc(HFL_IDX_SPEED, 32'h0000_FFFF, 4'h1, HFL_RESP_OKAY);
        rdc(HFL_IDX_SPEED, 32'h0000_00FF, HFL_RESP_OKAY);
        chk(ring_rate_select_o, 1'b1, "rate 4 Mbps");
        $display("test speed done");
        // one tick every 400 cycles; read points sit mid-interval
        wrc(HFL_IDX_IRQ_CMD, 32'h1, 4'h1, HFL_RESP_OKAY);
        chk(irq_o, 1'b1, "interrupt raised");
        repeat (1000) @(posedge clk_sys_i);
        rdc(HFL_IDX_TIMER, 32'h2, HFL_RESP_OKAY);
        wrc(HFL_IDX_IRQ_CMD, 32'h1, 4'h1, HFL_RESP_OKAY);
        repeat (450) @(posedge clk_sys_i);
        rdc(HFL_IDX_TIMER, 32'h3, HFL_RESP_OKAY);
        ce_i <= 1'b0; // frozen across a full tick interval
        repeat (450) @(posedge clk_sys_i);
        ce_i <= 1'b1;
        rdc(HFL_IDX_TIMER, 32'h3, HFL_RESP_OKAY);
        wrc(HFL_IDX_IRQ_CMD, 32'h2, 4'h1, HFL_RESP_OKAY);
        rdc(HFL_IDX_IRQ_STAT, 32'h0, HFL_RESP_OKAY);
        @(posedge clk_sys_i);
        irq_event_i <= 1'b1;
        @(posedge clk_sys_i);
        irq_event_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        rdc(HFL_IDX_TIMER, 32'h0, HFL_RESP_OKAY);
        repeat (102200) @(posedge clk_sys_i);
        rdc(HFL_IDX_TIMER, 32'hFF, HFL_RESP_OKAY);
        repeat (800) @(posedge clk_sys_i);
        rdc(HFL_IDX_TIMER, 32'hFF, HFL_RESP_OKAY);
        $display("test timer done");
        finish_test();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (110000) @(posedge clk_sys_i);
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule // hfl_regs_bench
